/* File: gpio_pkg.sv */
package gpio_pkg;

	localparam int DATA_W = 8;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_B_INPUT_ENABLE = 8'h0E;
	localparam logic [7:0] IDX_A_DATA = 8'h10;
	localparam logic [7:0] IDX_A_DIRECTION = 8'h11;
	localparam logic [7:0] IDX_A_PULLUP = 8'h12;
	localparam logic [7:0] IDX_B_DATA = 8'h14;
	localparam logic [7:0] IDX_B_DIRECTION = 8'h15;
	localparam logic [7:0] IDX_B_PULLUP = 8'h16;
	localparam logic [7:0] IDX_B_PULLDOWN = 8'h38;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
	localparam logic [7:0] IDX_WAKE_STATUS = 8'h42;

	localparam logic [7:0] RST_B_INPUT_ENABLE = 8'hFF;
	localparam logic [7:0] RST_A_DATA = 8'h00;
	localparam logic [7:0] RST_A_DIRECTION = 8'h00;
	localparam logic [7:0] RST_A_PULLUP = 8'h00;
	localparam logic [7:0] RST_B_DATA = 8'h00;
	localparam logic [7:0] RST_B_DIRECTION = 8'h00;
	localparam logic [7:0] RST_B_PULLUP = 8'h00;
	localparam logic [7:0] RST_B_PULLDOWN = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;

	// Writable bit masks
	localparam logic [7:0] B_PULLUP_MASK = 8'hFE;
	localparam logic [7:0] B_PULLDOWN_MASK = 8'h48;
	// Pins whose edges raise wake-up and interrupt requests
	localparam logic [7:0] B_EVENT_PINS = 8'h21;
	localparam int OPEN_DRAIN_PIN = 5;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0] drive;
		logic [7:0] oe;
		logic [7:0] pu_en;
		logic [7:0] pd_en;
	} pin_ctrl_type;

endpackage : gpio_pkg

/* File: pin_sampler.sv */
`timescale 1ns/1ps
module pin_sampler
	import gpio_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] input_enable,
	output logic [7:0] level,
	output logic [7:0] edge_seen
);
	logic [7:0] gated;
	logic [7:0] meta_r;
	logic [7:0] sync_r;
	logic [7:0] prev_r;

	// A disabled input reads as constant 0
	assign gated = pin_in & input_enable;

	// Two-stage synchroniser before any use
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= 8'h00;
			sync_r <= 8'h00;
			prev_r <= 8'h00;
		end else begin
			meta_r <= gated;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level = sync_r;
	assign edge_seen = sync_r ^ prev_r;
endmodule : pin_sampler

/* File: pin_driver.sv */
`timescale 1ns/1ps
module pin_driver
	import gpio_pkg::*;
(
	input wire logic [7:0] data,
	input wire logic [7:0] direction,
	input wire logic [7:0] pu_en,
	input wire logic [7:0] pd_en,
	input wire logic open_drain_en,
	output gpio_pkg::pin_ctrl_type ctrl
);
	logic [7:0] od_mask;

	always_comb begin
		od_mask = 8'h00;
		od_mask[OPEN_DRAIN_PIN] = open_drain_en;
	end

	always_comb begin
		ctrl.drive = data & direction & ~od_mask;
		// Open-drain pin releases instead of driving high
		ctrl.oe = direction & ~(od_mask & data);
		ctrl.pu_en = pu_en & ~direction;
		ctrl.pd_en = pd_en & ~direction;
	end
endmodule : pin_driver

/* File: dual_port_gpio_regs.sv */
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module dual_port_gpio_regs
	import gpio_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] port_a_in,
	input wire logic [7:0] port_b_in,
	output gpio_pkg::pin_ctrl_type port_a_ctrl,
	output gpio_pkg::pin_ctrl_type port_b_ctrl,
	output logic wake_request,
	output logic irq
);
	typedef enum {ADDR_A_DATA, ADDR_A_DIR, ADDR_A_PU, ADDR_B_DATA,
		ADDR_B_DIR, ADDR_B_PU, ADDR_B_PD, ADDR_B_IE, ADDR_ISTAT,
		ADDR_IMASK, ADDR_WSTAT, ADDR_NONE} reg_sel_type;

	function automatic reg_sel_type decode(input logic [31:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		if (addr[31:10] != 22'h0 || addr[1:0] != 2'h0)
			decode = ADDR_NONE;
		else begin
			case (idx)
				IDX_A_DATA: decode = ADDR_A_DATA;
				IDX_A_DIRECTION: decode = ADDR_A_DIR;
				IDX_A_PULLUP: decode = ADDR_A_PU;
				IDX_B_DATA: decode = ADDR_B_DATA;
				IDX_B_DIRECTION: decode = ADDR_B_DIR;
				IDX_B_PULLUP: decode = ADDR_B_PU;
				IDX_B_PULLDOWN: decode = ADDR_B_PD;
				IDX_B_INPUT_ENABLE: decode = ADDR_B_IE;
				IDX_IRQ_STATUS: decode = ADDR_ISTAT;
				IDX_IRQ_MASK: decode = ADDR_IMASK;
				IDX_WAKE_STATUS: decode = ADDR_WSTAT;
				default: decode = ADDR_NONE;
			endcase
		end
	endfunction : decode

	logic [7:0] a_data_r;
	logic [7:0] a_dir_r;
	logic [7:0] a_pu_r;
	logic [7:0] b_data_r;
	logic [7:0] b_dir_r;
	logic [7:0] b_pu_r;
	logic [7:0] b_pd_r;
	logic [7:0] b_ie_r;
	logic [7:0] istat_r;
	logic [7:0] imask_r;
	logic [7:0] wstat_r;

	logic [31:0] awaddr_r;
	logic [7:0] wdata_r;
	logic wstrb0_r;
	logic aw_held_r;
	logic w_held_r;
	logic wr_go;
	reg_sel_type wsel;
	logic [7:0] wv;
	reg_sel_type rsel;

	logic [7:0] a_level;
	logic [7:0] b_level;
	logic [7:0] b_edges;
	logic [7:0] events;
	pin_ctrl_type a_ctrl;
	pin_ctrl_type b_ctrl;

	// Each half waits in its holding register until the other arrives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r <= 32'h0;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wdata_r <= 8'h00;
			wstrb0_r <= 1'b0;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata[7:0];
			wstrb0_r <= s_axi_wstrb[0];
		end
	end

	assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wsel = decode(awaddr_r);
	assign wv = wdata_r;

	// Accepted write with byte lane 0 aimed at one register
	function automatic logic wr_hit(input reg_sel_type sel);
		wr_hit = wr_go && wstrb0_r && (wsel == sel);
	endfunction : wr_hit

	// Ready falls at the taking edge, so each channel takes one item
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_axi_awready <= 1'b0;
		else
			s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready)
				&& !s_axi_bvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_axi_wready <= 1'b0;
		else
			s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready)
				&& !s_axi_bvalid;
	end

	// Unmapped addresses answer with an error and change nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wsel == ADDR_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register writes; byte lane 0 carries all data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_data_r <= RST_A_DATA;
			a_dir_r <= RST_A_DIRECTION;
			a_pu_r <= RST_A_PULLUP;
		end else if (wr_go && wstrb0_r) begin
			case (wsel)
				ADDR_A_DATA: a_data_r <= wv;
				ADDR_A_DIR: a_dir_r <= wv;
				ADDR_A_PU: a_pu_r <= wv;
				default: ;
			endcase
		end
	end

	// Reserved pull bits are held at zero and read back as zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			b_data_r <= RST_B_DATA;
			b_dir_r <= RST_B_DIRECTION;
			b_pu_r <= RST_B_PULLUP;
			b_pd_r <= RST_B_PULLDOWN;
			b_ie_r <= RST_B_INPUT_ENABLE;
		end else if (wr_go && wstrb0_r) begin
			case (wsel)
				ADDR_B_DATA: b_data_r <= wv;
				ADDR_B_DIR: b_dir_r <= wv;
				ADDR_B_PU: b_pu_r <= wv & B_PULLUP_MASK;
				ADDR_B_PD: b_pd_r <= wv & B_PULLDOWN_MASK;
				ADDR_B_IE: b_ie_r <= wv;
				default: ;
			endcase
		end
	end

	// Only pins with wake-up and interrupt paths have mask bits
	always_ff @(posedge aclk) begin
		if (!aresetn)
			imask_r <= RST_IRQ_MASK;
		else if (wr_hit(ADDR_IMASK))
			imask_r <= wv & B_EVENT_PINS;
	end

	// Port A input enable sits outside this block, so its inputs stay on
	pin_sampler u_sample_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(port_a_in),
		.input_enable(8'hFF),
		.level(a_level),
		.edge_seen()
	);

	// Port B enables gate the pins ahead of the synchroniser
	pin_sampler u_sample_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(port_b_in),
		.input_enable(b_ie_r),
		.level(b_level),
		.edge_seen(b_edges)
	);

	// Gating also stops a pending edge after the enable drops
	assign events = b_edges & b_ie_r & B_EVENT_PINS;

	// Sticky status: a new event wins over a write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn)
			istat_r <= 8'h00;
		else if (wr_hit(ADDR_ISTAT))
			istat_r <= (istat_r & ~wv) | events;
		else
			istat_r <= istat_r | events;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			wstat_r <= 8'h00;
		else if (wr_hit(ADDR_WSTAT))
			wstat_r <= (wstat_r & ~wv) | events;
		else
			wstat_r <= wstat_r | events;
	end

	// Level output: high until every unmasked source is cleared
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(istat_r & imask_r);
	end

	// Wake-up ignores the mask and follows any pending wake status bit
	always_ff @(posedge aclk) begin
		if (!aresetn)
			wake_request <= 1'b0;
		else
			wake_request <= |wstat_r;
	end

	pin_driver u_drive_a (
		.data(a_data_r),
		.direction(a_dir_r),
		.pu_en(a_pu_r),
		.pd_en(8'h00),
		.open_drain_en(1'b1),
		.ctrl(a_ctrl)
	);

	pin_driver u_drive_b (
		.data(b_data_r),
		.direction(b_dir_r),
		.pu_en(b_pu_r),
		.pd_en(b_pd_r),
		.open_drain_en(1'b0),
		.ctrl(b_ctrl)
	);

	// Registered so the pads see no decode glitches
	always_ff @(posedge aclk) begin
		if (!aresetn)
			port_a_ctrl <= '0;
		else
			port_a_ctrl <= a_ctrl;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			port_b_ctrl <= '0;
		else
			port_b_ctrl <= b_ctrl;
	end

	// Output pins read back their data bit, input pins the synced level
	function automatic logic [7:0] readback(input logic [7:0] data,
		input logic [7:0] dir, input logic [7:0] level);
		readback = (data & dir) | (level & ~dir);
	endfunction : readback

	// Read channel: one-cycle answer after the address is taken
	function automatic logic [7:0] read_mux(input reg_sel_type sel);
		case (sel)
			ADDR_A_DATA: read_mux = readback(a_data_r, a_dir_r, a_level);
			ADDR_A_DIR: read_mux = a_dir_r;
			ADDR_A_PU: read_mux = a_pu_r;
			ADDR_B_DATA: read_mux = readback(b_data_r, b_dir_r, b_level);
			ADDR_B_DIR: read_mux = b_dir_r;
			ADDR_B_PU: read_mux = b_pu_r;
			ADDR_B_PD: read_mux = b_pd_r;
			ADDR_B_IE: read_mux = 8'h00;
			ADDR_ISTAT: read_mux = istat_r;
			ADDR_IMASK: read_mux = imask_r;
			ADDR_WSTAT: read_mux = wstat_r;
			default: read_mux = 8'h00;
		endcase
	endfunction : read_mux

	assign rsel = decode(s_axi_araddr);

	// One read in flight: ready returns once the answer is taken
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_axi_arready <= 1'b0;
		else
			s_axi_arready <= !s_axi_rvalid
				&& !(s_axi_arvalid && s_axi_arready);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h0, read_mux(rsel)};
			s_axi_rresp <= (rsel == ADDR_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : dual_port_gpio_regs

/* File: gpio_asserts.sv */
`timescale 1ns/1ps
module gpio_asserts
	import gpio_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire gpio_pkg::pin_ctrl_type port_a_ctrl,
	input wire gpio_pkg::pin_ctrl_type port_b_ctrl
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_a5_low: assert property (!port_a_ctrl.drive[5])
		else $error("A pin 5 driven high");
	chk_a_pu_in: assert property (~|(port_a_ctrl.pu_en & port_a_ctrl.oe))
		else $error("A pull-up on output");
	chk_b_pu_in: assert property (~|(port_b_ctrl.pu_en & port_b_ctrl.oe))
		else $error("B pull-up on output");
	chk_b_pu_bit0: assert property (!port_b_ctrl.pu_en[0])
		else $error("B pin 0 pull-up");
	chk_b_pd_bits: assert property (~|(port_b_ctrl.pd_en & 8'hB7))
		else $error("reserved pull-down");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer late");
	chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
endmodule : gpio_asserts

bind dual_port_gpio_regs gpio_asserts u_chk (.aclk, .aresetn, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .port_a_ctrl, .port_b_ctrl);

/* File: pin_board.sv */
`timescale 1ns/1ps
module pin_board
	import gpio_pkg::*;
(
	input wire gpio_pkg::pin_ctrl_type a_ctrl,
	input wire gpio_pkg::pin_ctrl_type b_ctrl,
	input wire logic [7:0] a_ext,
	input wire logic [7:0] b_ext,
	output logic [7:0] a_pin,
	output logic [7:0] b_pin
);
	// Undriven pins without a pull follow the board's own level
	function automatic logic [7:0] lvl(pin_ctrl_type c, logic [7:0] e);
		return (c.oe & c.drive) | (~c.oe & (c.pu_en | (~c.pd_en & e)));
	endfunction : lvl
	assign a_pin = lvl(a_ctrl, a_ext);
	assign b_pin = lvl(b_ctrl, b_ext);
endmodule : pin_board

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
	import gpio_pkg::*;
	logic aclk, aresetn, irq, wake;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [7:0] a_ext, b_ext, a_pin, b_pin;
	pin_ctrl_type a_ctrl, b_ctrl;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;

	dual_port_gpio_regs u_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .port_a_in(a_pin), .port_b_in(b_pin),
		.port_a_ctrl(a_ctrl), .port_b_ctrl(b_ctrl), .wake_request(wake),
		.irq);
	pin_board u_pins (.a_ctrl, .b_ctrl, .a_ext, .b_ext, .a_pin, .b_pin);

	task automatic chk(logic [31:0] got, logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic wr(logic [7:0] ix, logic [7:0] d, logic [1:0] er = 2'h0);
		@(posedge aclk);
		awaddr <= {22'h0, ix, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk(bresp, er);
	endtask : wr

	task automatic rd(logic [7:0] ix, logic [31:0] e, logic [1:0] er = 2'h0);
		@(posedge aclk);
		araddr <= {22'h0, ix, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk(rresp, er);
		if (er === RESP_OKAY) chk(rdata, e);
	endtask : rd

	task automatic t_reset;
		logic [7:0] ix[11] = '{IDX_B_INPUT_ENABLE, IDX_A_DATA, IDX_A_DIRECTION,
			IDX_A_PULLUP, IDX_B_DATA, IDX_B_DIRECTION, IDX_B_PULLUP,
			IDX_B_PULLDOWN, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_WAKE_STATUS};
		chk(a_ctrl, 32'h0);
		chk(b_ctrl, 32'h0);
		// Quiet pins, so every read is zero; input enable is write-only
		foreach (ix[i])
			rd(ix[i], 32'h0);
	endtask : t_reset

	task automatic t_events;
		wr(IDX_IRQ_MASK, 8'h21);
		b_ext <= 8'h22;
		repeat (8) @(posedge aclk);
		rd(IDX_IRQ_STATUS, 32'h20);
		rd(IDX_B_DATA, 32'h22);
		chk(irq, 1'b1);
		chk(wake, 1'b1);
		b_ext <= 8'h00;
		repeat (8) @(posedge aclk);
		wr(IDX_IRQ_STATUS, 8'h21);
		wr(IDX_WAKE_STATUS, 8'h21);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b0);
		chk(wake, 1'b0);
		wr(IDX_B_INPUT_ENABLE, 8'hDE);
		rd(IDX_B_INPUT_ENABLE, 32'h0);
		b_ext <= 8'h21;
		repeat (8) @(posedge aclk);
		rd(IDX_IRQ_STATUS, 32'h0);
		rd(IDX_WAKE_STATUS, 32'h0);
		rd(IDX_B_DATA, 32'h0);
		b_ext <= 8'h00;
		wr(IDX_B_INPUT_ENABLE, 8'hFF);
		wr(IDX_IRQ_MASK, 8'h00);
		b_ext <= 8'h01;
		repeat (8) @(posedge aclk);
		rd(IDX_IRQ_STATUS, 32'h01);
		chk(irq, 1'b0);
	endtask : t_events

	task automatic t_port_a;
		wr(IDX_A_DIRECTION, 8'hFF);
		wr(IDX_A_DATA, 8'hA5);
		repeat (2) @(posedge aclk);
		chk(a_ctrl.drive, 8'h85);
		chk(a_ctrl.oe, 8'hDF);
		rd(IDX_A_DATA, 32'hA5);
		wr(IDX_A_DIRECTION, 8'h0F);
		wr(IDX_A_DATA, 8'h05);
		wr(IDX_A_PULLUP, 8'hFF);
		repeat (4) @(posedge aclk);
		chk(a_ctrl.pu_en, 8'hF0);
		rd(IDX_A_PULLUP, 32'hFF);
		rd(IDX_A_DATA, 32'hF5);
	endtask : t_port_a

	task automatic t_port_b;
		wr(IDX_B_PULLUP, 8'hFF);
		wr(IDX_B_PULLDOWN, 8'hFF);
		rd(IDX_B_PULLUP, 32'hFE);
		rd(IDX_B_PULLDOWN, 32'h48);
		chk(b_ctrl.pu_en, 8'hFE);
		chk(b_ctrl.pd_en, 8'h48);
		wr(IDX_B_DIRECTION, 8'hFF);
		wr(IDX_B_DATA, 8'h3C);
		repeat (2) @(posedge aclk);
		chk(b_ctrl.pu_en, 8'h00);
		chk(b_ctrl.oe, 8'hFF);
		chk(b_ctrl.drive, 8'h3C);
		rd(IDX_B_DATA, 32'h3C);
		wr(8'h20, 8'hFF, RESP_SLVERR);
		rd(8'h20, 32'h0, RESP_SLVERR);
		wstrb <= 4'hE;
		wr(IDX_B_DATA, 8'hFF);
		wstrb <= 4'hF;
		rd(IDX_B_DATA, 32'h3C);
	endtask : t_port_b

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			wrap_up();
		end
	end

	initial begin
		aresetn <= 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
		{awaddr, wdata, araddr} <= 96'h0;
		wstrb <= 4'hF;
		{a_ext, b_ext} <= 16'h0000;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset();
		t_events();
		t_port_a();
		t_port_b();
		wrap_up();
	end
endmodule : tb
